// ===== design/abspt_pkg.sv
// Package for the absolute position transfer host sequencer.
// Assumes a single 50 MHz clock domain and no software register access.
package abspt_pkg;

  // Clock rate in kHz, used to derive cycle counts from millisecond figures.
  localparam int unsigned CLK_KHZ        = 50000;

  // Delay between send-ready falling and sampling the two data bits.
  localparam int unsigned SAMPLE_DLY_MS  = 10;
  localparam int unsigned SAMPLE_DLY_CYC = SAMPLE_DLY_MS * CLK_KHZ;

  // Handshake phase timeouts and the retry wait, chosen with margin over the sample delay.
  localparam int unsigned MODE_TO_MS     = 5000;
  localparam int unsigned MODE_TO_CYC    = MODE_TO_MS * CLK_KHZ;
  localparam int unsigned REQ_TO_MS      = 1000;
  localparam int unsigned REQ_TO_CYC     = REQ_TO_MS * CLK_KHZ;
  localparam int unsigned RDY_TO_MS      = 1000;
  localparam int unsigned RDY_TO_CYC     = RDY_TO_MS * CLK_KHZ;
  localparam int unsigned RETRY_WAIT_MS  = 100;
  localparam int unsigned RETRY_WAIT_CYC = RETRY_WAIT_MS * CLK_KHZ;

  // Frame layout: sixteen data groups, three checksum groups.
  localparam logic [4:0] DATA_GROUPS     = 5'h10;
  localparam logic [4:0] TOTAL_GROUPS    = 5'h13;
  localparam logic [1:0] MAX_RETRIES     = 2'h3;

  // Travel unit codes and conversion constants.
  localparam logic [1:0] UNIT_PULSE      = 2'h3;
  localparam logic [15:0] CONV_1UM       = 16'h000a;
  localparam logic [15:0] CONV_5UM       = 16'h0032;

  // Sequencer states.
  typedef enum logic [2:0] {
    ABSPT_IDLE,
    ABSPT_MODE,
    ABSPT_REQ,
    ABSPT_WAIT,
    ABSPT_REL,
    ABSPT_CHECK,
    ABSPT_RETRY,
    ABSPT_DONE
  } abspt_state_e;

endpackage : abspt_pkg

// ===== design/abspt_host.sv
// Host sequencer that reads an amplifier's absolute position over the
// two-bit digital handshake. Assumes amplifier pins are asynchronous.
`timescale 1ns/1ns

// How it works
// - On checksum mismatch the whole transfer restarts, at most three more times.
// - A mismatch after the last retry raises the checksum error and stops.
// - Mode on-time, request on-time and send-ready off-time are timed and raise the comm error.
// - Two-bit groups on data bits 0 and 1 build a 32-bit value in 16-bit halves.
// - Data bits are sampled 10 ms after send-ready signals a group.
// - By default the unit is code 3, pulses, one pulse per pulse.
// - Other units multiply the position by a conversion constant.
// - The constant is 10 for one micrometre and 50 for five micrometres per pulse.
// - The pulse unit passes the position through unchanged.
// - Deviation clear comes from a separate controller output.
// - A transfer holds sixteen data exchanges then the checksum exchanges.
// - The checksum is six bits over three exchanges, nineteen in all.
module abspt_host
#(
  parameter int unsigned SAMPLE_DLY = abspt_pkg::SAMPLE_DLY_CYC,
  parameter int unsigned MODE_TO    = abspt_pkg::MODE_TO_CYC,
  parameter int unsigned REQ_TO     = abspt_pkg::REQ_TO_CYC,
  parameter int unsigned RDY_TO     = abspt_pkg::RDY_TO_CYC,
  parameter int unsigned RETRY_WAIT = abspt_pkg::RETRY_WAIT_CYC
)
(
  input  wire logic        clock_i,               // 50 MHz clock.
  input  wire logic        rst_n_i,               // Sync reset, low.
  input  wire logic        clk_en_i,              // Freezes state when low.
  input  wire logic        start_i,               // Begin a transfer.
  input  wire logic [1:0]  unit_sel_i,            // Travel unit code.
  input  wire logic [15:0] conv_k_i,              // Conversion constant.
  input  wire logic        clear_req_i,           // Deviation clear cmd.
  input  wire logic        send_ready_in_i,       // Amplifier ready pin.
  input  wire logic        data_bit0_in_i,        // Data bit 0 pin.
  input  wire logic        data_bit1_in_i,        // Data bit 1 pin.
  output logic             servo_on_out_o,        // Servo-on drive.
  output logic             transfer_mode_out_o,   // Transfer mode drive.
  output logic             position_request_out_o,// Request drive.
  output logic             deviation_clear_o,     // Clear drive.
  output logic             checksum_error_out_o,  // Checksum error flag.
  output logic             comm_error_out_o,      // Comm error flag.
  output logic             busy_o,                // Transfer under way.
  output logic             pos_valid_o,           // Position ready.
  output logic [15:0]      pos_lo_o,              // Position low half.
  output logic [15:0]      pos_hi_o               // Position high half.
);

  // -------------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------------

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  wire        rdy_s  = sync_b[2];
  wire  [1:0] dat_s  = sync_b[1:0];

  // Two flops on every amplifier pin before any logic looks at it.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end
    else if (clk_en_i)
    begin
      sync_a <= {send_ready_in_i, data_bit1_in_i, data_bit0_in_i};
      sync_b <= sync_a;
    end
  end

  // -------------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------------

  abspt_pkg::abspt_state_e state;
  logic [31:0] timer;
  logic [4:0]  group;
  logic [1:0]  retries;
  logic [31:0] shift;
  logic [5:0]  sum;
  logic [5:0]  csum;
  logic        start_q;

  // Data groups enter from the top, so the first group lands lowest.
  wire         in_data   = group < abspt_pkg::DATA_GROUPS;
  wire         last_grp  = group == abspt_pkg::TOTAL_GROUPS - 5'h01;
  wire         sum_ok    = sum == csum;
  wire         start_ev  = start_i & ~start_q;
  wire         out_retry = retries == abspt_pkg::MAX_RETRIES;
  wire [5:0]   next_sum  = sum + {4'h0, dat_s};

  // Pulse unit passes through, others are scaled by the constant.
  wire         is_pulse  = unit_sel_i == abspt_pkg::UNIT_PULSE;
  wire [47:0]  product   = {16'h0000, shift} * {32'h0, conv_k_i};
  wire [31:0]  next_pos  = is_pulse ? shift : product[31:0];

  // Clear is a plain controller output, never tied to pulse starts.
  assign deviation_clear_o = clear_req_i;
  assign busy_o            = (state != abspt_pkg::ABSPT_IDLE) &&
                             (state != abspt_pkg::ABSPT_DONE);

  // Main handshake sequencer; one timer is shared by every phase.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state                  <= abspt_pkg::ABSPT_IDLE;
      timer                  <= 32'h0;
      group                  <= 5'h0;
      retries                <= 2'h0;
      shift                  <= 32'h0;
      sum                    <= 6'h0;
      csum                   <= 6'h0;
      start_q                <= 1'b0;
      servo_on_out_o         <= 1'b0;
      transfer_mode_out_o    <= 1'b0;
      position_request_out_o <= 1'b0;
      checksum_error_out_o   <= 1'b0;
      comm_error_out_o       <= 1'b0;
      pos_valid_o            <= 1'b0;
      pos_lo_o               <= 16'h0;
      pos_hi_o               <= 16'h0;
    end
    else if (clk_en_i)
    begin
      start_q <= start_i;
      timer   <= timer + 32'h1;
      case (state)
        abspt_pkg::ABSPT_IDLE, abspt_pkg::ABSPT_DONE:
        begin
          // A new start covers power-up, run edge, alarm and stop resets.
          if (start_ev)
          begin
            servo_on_out_o       <= 1'b1;
            transfer_mode_out_o  <= 1'b1;
            checksum_error_out_o <= 1'b0;
            comm_error_out_o     <= 1'b0;
            pos_valid_o          <= 1'b0;
            retries              <= 2'h0;
            group                <= 5'h0;
            sum                  <= 6'h0;
            timer                <= 32'h0;
            state                <= abspt_pkg::ABSPT_MODE;
          end
        end
        abspt_pkg::ABSPT_MODE:
        begin
          // Amplifier answers transfer mode by raising send-ready.
          if (rdy_s)
          begin
            position_request_out_o <= 1'b1;
            timer                  <= 32'h0;
            state                  <= abspt_pkg::ABSPT_REQ;
          end
          else if (timer >= MODE_TO)
          begin
            comm_error_out_o    <= 1'b1;
            transfer_mode_out_o <= 1'b0;
            state               <= abspt_pkg::ABSPT_DONE;
          end
        end
        abspt_pkg::ABSPT_REQ:
        begin
          // Request on-time: send-ready must drop to present a group.
          if (!rdy_s)
          begin
            timer <= 32'h0;
            state <= abspt_pkg::ABSPT_WAIT;
          end
          else if (timer >= REQ_TO)
          begin
            comm_error_out_o       <= 1'b1;
            position_request_out_o <= 1'b0;
            transfer_mode_out_o    <= 1'b0;
            state                  <= abspt_pkg::ABSPT_DONE;
          end
        end
        abspt_pkg::ABSPT_WAIT:
        begin
          // Settle the data pins before sampling them.
          if (timer >= SAMPLE_DLY - 1)
          begin
            if (in_data)
            begin
              shift <= {dat_s, shift[31:2]};
              sum   <= next_sum;
            end
            else
              csum  <= {dat_s, csum[5:2]};
            position_request_out_o <= 1'b0;
            timer                  <= 32'h0;
            state                  <= abspt_pkg::ABSPT_REL;
          end
        end
        abspt_pkg::ABSPT_REL:
        begin
          // Send-ready off-time is bounded after the request is released.
          if (rdy_s)
          begin
            timer <= 32'h0;
            group <= group + 5'h01;
            if (last_grp)
              state <= abspt_pkg::ABSPT_CHECK;
            else
            begin
              position_request_out_o <= 1'b1;
              state                  <= abspt_pkg::ABSPT_REQ;
            end
          end
          else if (timer >= RDY_TO)
          begin
            comm_error_out_o    <= 1'b1;
            transfer_mode_out_o <= 1'b0;
            state               <= abspt_pkg::ABSPT_DONE;
          end
        end
        abspt_pkg::ABSPT_CHECK:
        begin
          transfer_mode_out_o <= 1'b0;
          timer               <= 32'h0;
          if (sum_ok)
          begin
            pos_lo_o    <= next_pos[15:0];
            pos_hi_o    <= next_pos[31:16];
            pos_valid_o <= 1'b1;
            state       <= abspt_pkg::ABSPT_DONE;
          end
          else if (out_retry)
          begin
            checksum_error_out_o <= 1'b1;
            state                <= abspt_pkg::ABSPT_DONE;
          end
          else
          begin
            retries <= retries + 2'h1;
            state   <= abspt_pkg::ABSPT_RETRY;
          end
        end
        abspt_pkg::ABSPT_RETRY:
        begin
          // Mode stays low for a while so the amplifier restarts cleanly.
          if (timer >= RETRY_WAIT - 1)
          begin
            group               <= 5'h0;
            sum                 <= 6'h0;
            timer               <= 32'h0;
            transfer_mode_out_o <= 1'b1;
            state               <= abspt_pkg::ABSPT_MODE;
          end
        end
        default:
          state <= abspt_pkg::ABSPT_IDLE;
      endcase
    end
  end

endmodule : abspt_host

// ===== testbench/abspt_host_checker.sv
// Checker for the position transfer host, bound to its top ports.
// Assumes the sim parameter values chosen by the bench.
`timescale 1ns/1ns
module abspt_host_checker
#(
  parameter int unsigned SAMPLE_DLY = 4,
  parameter int unsigned MODE_TO    = 200
)
(
  input wire logic clock_i,                // Clock.
  input wire logic rst_n_i,                // Reset, low.
  input wire logic clk_en_i,               // Enable.
  input wire logic start_i,                // Start.
  input wire logic clear_req_i,            // Clear command.
  input wire logic send_ready_in_i,        // Ready pin.
  input wire logic servo_on_out_o,         // Servo-on.
  input wire logic transfer_mode_out_o,    // Mode.
  input wire logic position_request_out_o, // Request.
  input wire logic deviation_clear_o,      // Clear out.
  input wire logic checksum_error_out_o,   // Sum error.
  input wire logic comm_error_out_o,       // Comm error.
  input wire logic busy_o,                 // Busy.
  input wire logic pos_valid_o             // Valid.
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] wait_cnt;
  // Cycles spent waiting for send-ready with request low; bounds the mode and release waits.
  always_ff @(posedge clock_i)
    if (!rst_n_i || !transfer_mode_out_o || position_request_out_o
        || send_ready_in_i) wait_cnt <= 32'h0;
    else if (clk_en_i) wait_cnt <= wait_cnt + 32'h1;
  sequence s_mode_gap; !transfer_mode_out_o [*6]; endsequence
  sequence s_req_hold; position_request_out_o [*5]; endsequence
  property p_clear; deviation_clear_o == clear_req_i; endproperty
  property p_req_mode;
    position_request_out_o |-> transfer_mode_out_o; endproperty
  property p_req_hold; $rose(position_request_out_o) |-> s_req_hold;
  endproperty
  property p_sample; $fell(position_request_out_o) && !comm_error_out_o
    |-> $past(send_ready_in_i, SAMPLE_DLY + 2) == 1'b0; endproperty
  property p_retry_gap; $fell(transfer_mode_out_o) |-> s_mode_gap;
  endproperty
  property p_wait_bound; wait_cnt <= MODE_TO + 32'd4; endproperty
  property p_done; $rose(pos_valid_o) |-> !busy_o && !transfer_mode_out_o
    && !checksum_error_out_o && !comm_error_out_o; endproperty
  property p_start; $rose(start_i) && !busy_o && clk_en_i
    |=> transfer_mode_out_o && servo_on_out_o; endproperty
  property p_err_hold; (checksum_error_out_o || comm_error_out_o)
    && !$rose(start_i) |=> $stable({checksum_error_out_o,
    comm_error_out_o}); endproperty
  a_clear: assert property (p_clear) else $error("clear mismatch");
  a_req_mode: assert property (p_req_mode) else $error("req no mode");
  a_req_hold: assert property (p_req_hold) else $error("req short");
  a_sample: assert property (p_sample) else $error("early sample");
  a_retry_gap: assert property (p_retry_gap) else $error("no gap");
  a_wait_bound: assert property (p_wait_bound) else $error("no tmo");
  a_done: assert property (p_done) else $error("bad done");
  a_start: assert property (p_start) else $error("no start");
  a_err_hold: assert property (p_err_hold) else $error("err lost");
endmodule : abspt_host_checker
bind abspt_host abspt_host_checker #(.SAMPLE_DLY(SAMPLE_DLY),
  .MODE_TO(MODE_TO)) u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .clk_en_i(clk_en_i), .start_i(start_i), .clear_req_i(clear_req_i),
  .send_ready_in_i(send_ready_in_i), .servo_on_out_o(servo_on_out_o),
  .transfer_mode_out_o(transfer_mode_out_o),
  .position_request_out_o(position_request_out_o),
  .deviation_clear_o(deviation_clear_o), .busy_o(busy_o),
  .checksum_error_out_o(checksum_error_out_o),
  .comm_error_out_o(comm_error_out_o), .pos_valid_o(pos_valid_o));

// ===== testbench/abspt_amp_model.sv
// Behavioural amplifier side of the two-bit position handshake.
// Assumes the host raises mode, then one request per group.
`timescale 1ns/1ns
module abspt_amp_model
(
  input wire logic        clock_i, // Clock.
  input wire logic        rst_n_i, // Reset, low.
  input wire logic        clr_i,   // Power-up or alarm reset event.
  input wire logic        mode_i,  // Transfer mode.
  input wire logic        req_i,   // Request.
  input wire logic        mute_i,  // Never answer.
  input wire logic        slow_i,  // Answer late.
  input wire logic [2:0]  bad_i,   // Attempts sent with a bad sum.
  input wire logic [31:0] pos_i,   // Position to send.
  output logic            rdy_o,   // Send-ready.
  output logic [1:0]      dat_o    // Data bits 1 and 0.
);
  logic req_q, mode_q;
  logic [4:0] g, wt;
  logic [2:0] att;
  logic [5:0] cks;
  logic [1:0] grp;
  // Sum of the data groups, spoiled while attempts remain to corrupt.
  always_comb
  begin
    cks = 6'h0;
    for (int i = 0; i < 16; i++) cks = cks + 6'(pos_i[2*i+:2]);
    if (att < bad_i) cks = cks ^ 6'h01;
    grp = g[4] ? cks[{g[1:0], 1'b0}+:2] : pos_i[{g[3:0], 1'b0}+:2];
  end
  // Data lines show the inverse once released, so a stale sample shows.
  always_ff @(posedge clock_i)
  begin
    req_q <= req_i;
    mode_q <= mode_i;
    if (!rst_n_i || clr_i) att <= 3'h0;
    else if (mode_q && !mode_i) att <= att + 3'h1;
    if (!rst_n_i) dat_o <= 2'h1;
    if (!rst_n_i || !mode_i) {rdy_o, g, wt} <= 11'h0;
    else if (req_i && !req_q) {rdy_o, wt, dat_o} <= {6'h0, grp};
    else if (!req_i && req_q) {g, wt, dat_o} <= {g + 5'h1, 5'h0, ~dat_o};
    else if (!req_i && !rdy_o && !mute_i)
    begin
      wt <= wt + 5'h1;
      if (wt >= (slow_i ? 5'd20 : 5'd1)) rdy_o <= 1'b1;
    end
  end
endmodule : abspt_amp_model

// ===== testbench/test_abspt_host.sv
// Self-checking bench for the position transfer host.
// Assumes the amplifier model and the bound checker.
`timescale 1ns/1ns
module test_abspt_host;
  logic clock_i = 0, rst_n_i = 0, start_i = 0, clear_req_i = 0;
  logic [1:0] unit_sel_i = 2'h3;
  logic [15:0] conv_k_i = 16'h0, lo, hi;
  logic mute = 0, slow = 0, rdy, servo, mode, req, dclr, cks, comm, busy;
  logic valid, busy_q = 0, en = 1;
  logic [2:0] bad = 3'h0;
  logic [1:0] dat;
  logic [31:0] pos = 32'h0, seed = 32'h9d7a;
  logic [34:0] expq[$], e;
  int mismatches = 0, n_tests = 0;
  always #10 clock_i = ~clock_i;
  // Random enable gaps only while busy, so a start pulse is never lost.
  always @(posedge clock_i) en <= busy !== 1'b1 || (xs() & 32'h3) != 32'h0;
  abspt_host #(.SAMPLE_DLY(4), .MODE_TO(200), .REQ_TO(100), .RDY_TO(100),
    .RETRY_WAIT(8)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .clk_en_i(en), .start_i(start_i), .unit_sel_i(unit_sel_i),
    .conv_k_i(conv_k_i), .clear_req_i(clear_req_i),
    .send_ready_in_i(rdy), .data_bit0_in_i(dat[0]), .data_bit1_in_i(dat[1]),
    .servo_on_out_o(servo), .transfer_mode_out_o(mode),
    .position_request_out_o(req), .deviation_clear_o(dclr),
    .checksum_error_out_o(cks), .comm_error_out_o(comm), .busy_o(busy),
    .pos_valid_o(valid), .pos_lo_o(lo), .pos_hi_o(hi));
  abspt_amp_model amp (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .clr_i(start_i), .mode_i(mode), .req_i(req), .mute_i(mute),
    .slow_i(slow), .bad_i(bad), .pos_i(pos), .rdy_o(rdy), .dat_o(dat));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // Compares the oldest note once busy has fallen and outputs settled.
  always @(posedge clock_i)
  begin
    busy_q <= busy;
    if (busy_q === 1'b1 && busy === 1'b0)
    begin
      e = expq.pop_front();
      if (!e[34]) check({valid, cks, comm, 32'h0}, {e[34:32], 32'h0});
      else check({valid, cks, comm, hi, lo}, e);
    end
  end
  // One transfer; a second start while busy must be ignored.
  task automatic run(input logic [1:0] u, input logic [15:0] k,
    input logic [2:0] b, input logic m, input logic s);
    logic [31:0] v;
    @(posedge clock_i);
    v = xs();
    pos <= v;
    {unit_sel_i, conv_k_i, bad, mute, slow, clear_req_i} <= {u, k, b, m, s, v[0]};
    expq.push_back({!m && b < 4, !m && b > 3, m, u == 2'h3 ? v : v * {16'h0, k}});
    @(posedge clock_i) start_i <= 1'b1;
    @(posedge clock_i) start_i <= 1'b0;
    repeat (30) @(posedge clock_i);
    start_i <= 1'b1;
    @(posedge clock_i) start_i <= 1'b0;
    while (busy !== 1'b0) @(posedge clock_i);
    repeat (10) @(posedge clock_i);
    $display("test done unit %0d k %0d bad %0d mute %0d", u, k, b, m);
  endtask : run
  initial
  begin
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    run(2'h3, 16'h0, 3'h0, 1'b0, 1'b0);
    run(2'h0, abspt_pkg::CONV_1UM, 3'h0, 1'b0, 1'b1);
    run(2'h1, abspt_pkg::CONV_5UM, 3'h2, 1'b0, 1'b0);
    run(2'h2, abspt_pkg::CONV_1UM, 3'h3, 1'b0, 1'b0);
    run(2'h3, 16'h0, 3'h4, 1'b0, 1'b1);
    run(2'h3, 16'h0, 3'h0, 1'b1, 1'b0);
    run(2'h3, 16'h0, 3'h0, 1'b0, 1'b0);
    check(35'(expq.size()), 35'h0);
    complete_run();
  end
  // Cuts a hang short well past the longest expected run.
  initial
  begin
    repeat (30000) @(posedge clock_i);
    mismatches++;
    complete_run();
  end
endmodule : test_abspt_host
